// [pkg/nvpsc_pkg.sv]
// Purpose: Shared constants and types for the NVM protect/status/command block
// Assumes: AHB-Lite word registers, 125 MHz hclk
// Notes:   Lower protection field values guard more of the array
package nvpsc_pkg;
    // ********************************
    // Register map (byte addresses)
    // ********************************
    localparam logic [7:0] OFS_PROT = 8'h00;
    localparam logic [7:0] OFS_STAT = 8'h04;
    localparam logic [7:0] OFS_CMD = 8'h08;
    localparam logic [7:0] OFS_ADDR = 8'h0C;
    localparam logic [7:0] OFS_DATA = 8'h10;
    localparam logic [7:0] OFS_CDIV = 8'h14;
    // ********************************
    // Status and divider bit positions
    // ********************************
    localparam int BIT_CBEF = 7;
    localparam int BIT_CCF = 6;
    localparam int BIT_PVIOL = 5;
    localparam int BIT_ACCERR = 4;
    localparam int BIT_BLANK = 2;
    localparam int BIT_CDIV_INIT = 7;
    // ********************************
    // Command codes
    // ********************************
    localparam logic [7:0] CMD_BLANK = 8'h05;
    localparam logic [7:0] CMD_BYTE_PROG = 8'h20;
    localparam logic [7:0] CMD_BURST_PROG = 8'h25;
    localparam logic [7:0] CMD_SECT_ERASE = 8'h40;
    localparam logic [7:0] CMD_MASS_ERASE = 8'h41;
    localparam logic [7:0] CMD_ERASE_ABORT = 8'h47;
    // ********************************
    // Protection decoding
    // ********************************
    localparam logic [1:0] EE_GUARD_NONE = 2'h3;
    localparam logic [5:0] FL_GUARD_NONE = 6'h3F;
    localparam logic [5:0] FL_GUARD_ALL_MAX = 6'h18;
    localparam logic [16:0] TOP_PLUS1 = 17'h1_0000;
    localparam logic [16:0] FLASH_STEP = 17'h0_0600;
    localparam logic [16:0] EE_LOW_2 = 17'h0_17F0;
    localparam logic [16:0] EE_LOW_1 = 17'h0_17E0;
    localparam logic [16:0] EE_LOW_0 = 17'h0_17C0;
    localparam logic [15:0] EE_TOP = 16'h17FF;
    // ********************************
    // Reset and unlock values
    // ********************************
    localparam logic [7:0] PROT_RST = 8'hFF;
    localparam logic [1:0] SECURITY_RST = 2'h3;
    localparam logic [1:0] SECURITY_UNLOCKED = 2'h2;
    localparam logic [7:0] ZERO8 = 8'h00;
    // Request carried to the array sequencer
    typedef struct packed {
        logic [7:0] op;
        logic [15:0] addr;
        logic [7:0] data;
    } nvpsc_req_t;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_RUN = 2'b10
    } nvpsc_state_t;
endpackage

// [logic/nvpsc_top.sv]
// Purpose: Protection, status and command logic of an on-chip Flash/EEPROM controller
// Assumes: Array sequencer on hclk answers each nvm_go with one nvm_done pulse
// Notes:   Zero-wait AHB-Lite slave; registers sit in the low byte of each word, the address register in the low half-word
//
// How it works
// R1: Protection bits 7:6 select the guarded EEPROM area.
// R2: EEPROM field 3 none, 2 from 17F0, 1 from 17E0, 0 from 17C0.
// R3: Protection bits 5:0 select the guarded Flash area.
// R4: Flash 3F none, each step down guards 1.5K more, 18..00 guard all.
// R5: Writing one to buffer-empty launches; launch clears it, transfer to the array sets it again.
// R6: Only burst programs queue; buffer-empty shows whether the slot is free.
// R7: Complete flag set when idle and empty; cleared by launch; writes ignored.
// R8: Program/erase of a guarded address is dropped and sets violation; write one clears.
// R9: Sequence error, unset divider, or stop mid-command sets access error; the code checks the divider for program/erase commands only.
// R10: Writing one clears access error; zero does nothing.
// R11: Blank flag set by clean blank check; cleared by valid launch; writes ignored.
// R12: A clear blank flag means not erased only after a blank check completes.
// R13: Codes 05 blank check, 20 byte program, 25 burst program.
// R14: Codes 40 sector erase, 41 mass erase, 47 erase abort.
// R15: Any other command code raises access error.
// R16: Software needs blank check only for unlocking security.
// R17: Protection writes that shrink the guarded area are ignored.
// R18: Protection loads from the stored image right after reset.
// R19: Mass erase is refused while anything is guarded.
// R20: Clean Flash blank check sets security to the unsecured code.
// R21: Writing zero to buffer-empty does nothing; unused status bits read zero.
`timescale 1ns/100ps
module nvpsc_top (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [7:0] stored_protection_image,
    input wire logic [1:0] stored_security_image,
    input wire logic stop_req_pin,
    input wire logic nvm_done,
    input wire logic nvm_blank_ok,
    output nvpsc_pkg::nvpsc_req_t nvm_req,
    output logic nvm_go,
    output logic nvm_abort,
    output logic [7:0] nvm_clock_divider,
    output logic [1:0] security_state_field
);
    // ********************************
    // Bus front end
    // ********************************
    logic wr_pend_reg, wr_pend_next;
    logic [7:0] wr_ofs_reg, wr_ofs_next;
    logic [31:0] hrdata_reg, hrdata_next;
    logic stop_s1_reg, stop_s2_reg, stop_s3_reg;
    logic loaded_reg;
    // Register state
    logic [7:0] prot_reg, prot_next;
    logic [1:0] security_reg, security_next;
    logic cbef_reg, cbef_next;
    logic ccf_reg, ccf_next;
    logic pviol_reg, pviol_next;
    logic accerr_reg, accerr_next;
    logic blank_reg, blank_next;
    logic [7:0] cmd_reg, cmd_next;
    logic [15:0] addr_reg, addr_next;
    logic [7:0] data_reg, data_next;
    logic [7:0] cdiv_reg, cdiv_next;
    logic cdiv_init_reg, cdiv_init_next;
    logic cmd_wr_reg, cmd_wr_next;
    // Engine state
    nvpsc_pkg::nvpsc_state_t st_reg, st_next;
    logic pend_reg, pend_next;
    nvpsc_pkg::nvpsc_req_t pend_req_reg, pend_req_next;
    nvpsc_pkg::nvpsc_req_t run_req_reg, run_req_next;
    logic go_reg, go_next;
    logic abort_reg, abort_next;
    // Decode helpers
    logic addr_ph, wr_stat, wr_prot, launch, legal, prog_erase, hit, ee_hit, fl_hit;
    logic any_prot, seq_err, busy_err, launch_ok, launch_pv, launch_ae, stop_hit;
    logic [16:0] ee_low_cur, fl_low_cur, ee_low_new, fl_low_new;
    logic blank_done, unlock;
    // Lower bound of the guarded EEPROM window; 10000 means nothing guarded
    function automatic logic [16:0] ee_low(input logic [1:0] f);
        unique case (f)
            2'h3: ee_low = nvpsc_pkg::TOP_PLUS1;
            2'h2: ee_low = nvpsc_pkg::EE_LOW_2;
            2'h1: ee_low = nvpsc_pkg::EE_LOW_1;
            2'h0: ee_low = nvpsc_pkg::EE_LOW_0;
        endcase
    endfunction
    // Lower bound of guarded Flash; 18 and below all fold to address zero
    function automatic logic [16:0] fl_low(input logic [5:0] f);
        logic [16:0] steps;
        steps = {11'h000, nvpsc_pkg::FL_GUARD_NONE - f};
        if (f <= nvpsc_pkg::FL_GUARD_ALL_MAX) begin
            fl_low = 17'h0_0000;
        end else begin
            fl_low = 17'(nvpsc_pkg::TOP_PLUS1 - 17'(steps * nvpsc_pkg::FLASH_STEP));
        end
    endfunction
    // ********************************
    // Command checks
    // ********************************
    always_comb begin
        addr_ph = hsel & hready & htrans[1];
        wr_stat = wr_pend_reg & (wr_ofs_reg == nvpsc_pkg::OFS_STAT);
        wr_prot = wr_pend_reg & (wr_ofs_reg == nvpsc_pkg::OFS_PROT);
        launch = wr_stat & hwdata[nvpsc_pkg::BIT_CBEF] & cbef_reg;           // [R5] [R21]
        legal = (cmd_reg == nvpsc_pkg::CMD_BLANK) | (cmd_reg == nvpsc_pkg::CMD_BYTE_PROG)
            | (cmd_reg == nvpsc_pkg::CMD_BURST_PROG)                      // [R13]
            | (cmd_reg == nvpsc_pkg::CMD_SECT_ERASE)
            | (cmd_reg == nvpsc_pkg::CMD_MASS_ERASE)
            | (cmd_reg == nvpsc_pkg::CMD_ERASE_ABORT);                    // [R14]
        prog_erase = legal & (cmd_reg != nvpsc_pkg::CMD_BLANK)
            & (cmd_reg != nvpsc_pkg::CMD_ERASE_ABORT);
        ee_low_cur = ee_low(prot_reg[7:6]);                                 // [R1] [R2]
        fl_low_cur = fl_low(prot_reg[5:0]);                                 // [R3] [R4]
        ee_low_new = ee_low(hwdata[7:6]);
        fl_low_new = fl_low(hwdata[5:0]);
        ee_hit = ({1'b0, addr_reg} >= ee_low_cur) & (addr_reg <= nvpsc_pkg::EE_TOP);
        fl_hit = {1'b0, addr_reg} >= fl_low_cur;
        any_prot = (prot_reg[7:6] != nvpsc_pkg::EE_GUARD_NONE)
            | (prot_reg[5:0] != nvpsc_pkg::FL_GUARD_NONE);
        hit = (cmd_reg == nvpsc_pkg::CMD_MASS_ERASE) ? any_prot             // [R19]
            : (prog_erase & (ee_hit | fl_hit));                             // [R8]
        // Only a burst may queue behind a running burst
        busy_err = (st_reg == nvpsc_pkg::ST_RUN) & (cmd_reg != nvpsc_pkg::CMD_ERASE_ABORT)
            & ~((cmd_reg == nvpsc_pkg::CMD_BURST_PROG)
            & (run_req_reg.op == nvpsc_pkg::CMD_BURST_PROG));               // [R6]
        seq_err = ~cmd_wr_reg | ~legal | busy_err                           // [R15]
            | (prog_erase & ~cdiv_init_reg);                                // [R9]
        launch_ae = launch & seq_err;
        launch_pv = launch & ~seq_err & hit;
        launch_ok = launch & ~seq_err & ~hit;
        stop_hit = stop_s2_reg & ~stop_s3_reg & ((st_reg == nvpsc_pkg::ST_RUN) | pend_reg);
        blank_done = (st_reg == nvpsc_pkg::ST_RUN) & nvm_done
            & (run_req_reg.op == nvpsc_pkg::CMD_BLANK);
        unlock = blank_done & nvm_blank_ok & (run_req_reg.addr > nvpsc_pkg::EE_TOP);
    end
    // ********************************
    // Register file next state
    // ********************************
    always_comb begin
        wr_pend_next = addr_ph & hwrite;
        wr_ofs_next = haddr[7:0];
        hrdata_next = 32'h0000_0000;
        if (addr_ph & ~hwrite) begin
            unique case (haddr[7:0])
                nvpsc_pkg::OFS_PROT: hrdata_next = {24'h00_0000, prot_reg};
                nvpsc_pkg::OFS_STAT: hrdata_next = {24'h00_0000, cbef_reg, ccf_reg,
                    pviol_reg, accerr_reg, 1'b0, blank_reg, 2'b00};       // [R21]
                nvpsc_pkg::OFS_CMD: hrdata_next = {24'h00_0000, cmd_reg};
                nvpsc_pkg::OFS_ADDR: hrdata_next = {16'h0000, addr_reg};
                nvpsc_pkg::OFS_DATA: hrdata_next = {24'h00_0000, data_reg};
                nvpsc_pkg::OFS_CDIV: hrdata_next = {24'h00_0000, cdiv_reg};
                default: hrdata_next = 32'h0000_0000;
            endcase
        end
        prot_next = prot_reg;
        if (~loaded_reg) begin
            prot_next = stored_protection_image;                            // [R18]
        end else if (wr_prot & (ee_low_new <= ee_low_cur) & (fl_low_new <= fl_low_cur)) begin
            prot_next = hwdata[7:0];                                        // [R17]
        end
        security_next = security_reg;
        if (~loaded_reg) begin
            security_next = stored_security_image;
        end else if (unlock) begin
            security_next = nvpsc_pkg::SECURITY_UNLOCKED;                   // [R20]
        end
        cmd_next = cmd_reg;
        cmd_wr_next = cmd_wr_reg & ~launch;
        addr_next = addr_reg;
        data_next = data_reg;
        cdiv_next = cdiv_reg;
        cdiv_init_next = cdiv_init_reg;
        if (wr_pend_reg & (wr_ofs_reg == nvpsc_pkg::OFS_CMD)) begin
            cmd_next = hwdata[7:0];
            cmd_wr_next = 1'b1;
        end
        if (wr_pend_reg & (wr_ofs_reg == nvpsc_pkg::OFS_ADDR)) begin
            addr_next = hwdata[15:0];
        end
        if (wr_pend_reg & (wr_ofs_reg == nvpsc_pkg::OFS_DATA)) begin
            data_next = hwdata[7:0];
        end
        if (wr_pend_reg & (wr_ofs_reg == nvpsc_pkg::OFS_CDIV) & ~cdiv_init_reg) begin
            cdiv_next = {1'b0, hwdata[6:0]};
            cdiv_init_next = 1'b1;
        end
        // Set beats clear on every hardware-set flag
        pviol_next = (pviol_reg & ~(wr_stat & hwdata[nvpsc_pkg::BIT_PVIOL])) | launch_pv;
        accerr_next = (accerr_reg & ~(wr_stat & hwdata[nvpsc_pkg::BIT_ACCERR]))
            | launch_ae | stop_hit;                                         // [R9] [R10]
        blank_next = (blank_reg & ~launch_ok) | (blank_done & nvm_blank_ok); // [R11] [R12]
    end
    // ********************************
    // Command engine next state
    // ********************************
    always_comb begin
        st_next = st_reg;
        pend_next = pend_reg;
        pend_req_next = pend_req_reg;
        run_req_next = run_req_reg;
        go_next = 1'b0;
        abort_next = 1'b0;
        if (launch_ok & (cmd_reg == nvpsc_pkg::CMD_ERASE_ABORT)) begin
            // Abort only reaches the array while a sector erase runs
            abort_next = (st_reg == nvpsc_pkg::ST_RUN)
                & (run_req_reg.op == nvpsc_pkg::CMD_SECT_ERASE);            // [R14]
        end else if (launch_ok) begin
            pend_next = 1'b1;
            pend_req_next = '{op: cmd_reg, addr: addr_reg, data: data_reg};
        end
        unique case (st_reg)
            nvpsc_pkg::ST_IDLE: begin
                if (pend_reg) begin
                    st_next = nvpsc_pkg::ST_RUN;
                    run_req_next = pend_req_reg;
                    pend_next = 1'b0;                                       // [R5]
                    go_next = 1'b1;
                end
            end
            nvpsc_pkg::ST_RUN: begin
                if (nvm_done & pend_reg) begin
                    run_req_next = pend_req_reg;
                    pend_next = 1'b0;                                       // [R5] [R6]
                    go_next = 1'b1;
                end else if (nvm_done) begin
                    st_next = nvpsc_pkg::ST_IDLE;
                end
            end
        endcase
        if (stop_hit) begin
            // Stop drops the queue; the array is told to abandon its work
            st_next = nvpsc_pkg::ST_IDLE;
            pend_next = 1'b0;
            go_next = 1'b0;
            abort_next = 1'b1;                                              // [R9]
        end
        cbef_next = ~pend_next;                                             // [R5] [R6]
        ccf_next = (st_next == nvpsc_pkg::ST_IDLE) & ~pend_next;            // [R7]
    end
    // ********************************
    // Registers
    // ********************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_ofs_reg <= nvpsc_pkg::ZERO8;
            hrdata_reg <= 32'h0000_0000;
            stop_s1_reg <= 1'b0;
            stop_s2_reg <= 1'b0;
            stop_s3_reg <= 1'b0;
            loaded_reg <= 1'b0;
            prot_reg <= nvpsc_pkg::PROT_RST;
            security_reg <= nvpsc_pkg::SECURITY_RST;
            cbef_reg <= 1'b1;
            ccf_reg <= 1'b1;
            pviol_reg <= 1'b0;
            accerr_reg <= 1'b0;
            blank_reg <= 1'b0;
            cmd_reg <= nvpsc_pkg::ZERO8;
            addr_reg <= 16'h0000;
            data_reg <= nvpsc_pkg::ZERO8;
            cdiv_reg <= nvpsc_pkg::ZERO8;
            cdiv_init_reg <= 1'b0;
            cmd_wr_reg <= 1'b0;
            st_reg <= nvpsc_pkg::ST_IDLE;
            pend_reg <= 1'b0;
            pend_req_reg <= '0;
            run_req_reg <= '0;
            go_reg <= 1'b0;
            abort_reg <= 1'b0;
        end else begin
            wr_pend_reg <= wr_pend_next;
            wr_ofs_reg <= wr_ofs_next;
            hrdata_reg <= hrdata_next;
            stop_s1_reg <= stop_req_pin;
            stop_s2_reg <= stop_s1_reg;
            stop_s3_reg <= stop_s2_reg;
            loaded_reg <= 1'b1;
            prot_reg <= prot_next;
            security_reg <= security_next;
            cbef_reg <= cbef_next;
            ccf_reg <= ccf_next;
            pviol_reg <= pviol_next;
            accerr_reg <= accerr_next;
            blank_reg <= blank_next;
            cmd_reg <= cmd_next;
            addr_reg <= addr_next;
            data_reg <= data_next;
            cdiv_reg <= cdiv_next;
            cdiv_init_reg <= cdiv_init_next;
            cmd_wr_reg <= cmd_wr_next;
            st_reg <= st_next;
            pend_reg <= pend_next;
            pend_req_reg <= pend_req_next;
            run_req_reg <= run_req_next;
            go_reg <= go_next;
            abort_reg <= abort_next;
        end
    end
    // Outputs straight from flops or tied off; zero-wait slave never stalls or errors
    assign hrdata = hrdata_reg;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign nvm_req = run_req_reg;
    assign nvm_go = go_reg;
    assign nvm_abort = abort_reg;
    assign nvm_clock_divider = cdiv_reg;
    assign security_state_field = security_reg;
    // ********************************
    // Assertions
    // ********************************
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_launch_clears_busy: assert property (launch_ok & (cmd_reg != nvpsc_pkg::CMD_ERASE_ABORT)
        |=> !cbef_reg && !ccf_reg) else $error("launch did not clear flags"); // [R5]
    a_violation_drops_cmd: assert property (launch_pv |=> pviol_reg && !pend_reg ##1 !nvm_go)
        else $error("guarded command not dropped"); // [R8]
    a_illegal_code_err: assert property (launch & cmd_wr_reg & ~legal |=> accerr_reg)
        else $error("illegal code without access error"); // [R15]
    a_accerr_holds: assert property (accerr_reg & ~(wr_stat & hwdata[nvpsc_pkg::BIT_ACCERR])
        |=> accerr_reg) else $error("access error lost"); // [R10]
    a_blank_clear_launch: assert property (launch_ok & ~blank_done |=> !blank_reg)
        else $error("blank flag kept after launch"); // [R11]
    a_prot_no_shrink: assert property (loaded_reg & wr_prot & (fl_low_new > fl_low_cur)
        |=> prot_reg == $past(prot_reg)) else $error("protection shrank"); // [R17]
    a_mass_erase_refused: assert property (launch & ~seq_err & any_prot
        & (cmd_reg == nvpsc_pkg::CMD_MASS_ERASE) |=> pviol_reg)
        else $error("mass erase not refused"); // [R19]
    a_unlock_security: assert property (unlock |=> security_state_field == 2'h2)
        else $error("security not unlocked"); // [R20]
    a_complete_when_idle: assert property (st_reg == nvpsc_pkg::ST_IDLE && !pend_reg
        && !launch |=> ccf_reg) else $error("complete flag missing"); // [R7]
    a_zero_write_inert: assert property (wr_stat & ~hwdata[nvpsc_pkg::BIT_CBEF]
        & ~pend_reg & ~stop_hit & (st_reg == nvpsc_pkg::ST_IDLE) |=> !nvm_go[*2])
        else $error("zero write launched"); // [R21]
endmodule // nvpsc_top

// [tb/nvpsc_top_bench.sv]
// Purpose: Self-checking bench for the NVM protect/status/command block
// Assumes: Zero-wait slave; the bench plays the array sequencer by hand
// Notes:   Protection rows first, then command, error and queue cases
`timescale 1ns/100ps
module nvpsc_top_bench;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, stop_req_pin, nvm_done, nvm_blank_ok;
    logic nvm_go, nvm_abort;
    logic [1:0] htrans, secst, simg;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [7:0] div, img;
    nvpsc_pkg::nvpsc_req_t req;
    int failures = 0, n_checks = 0, go_cnt = 0, g0 = 0, ab_cnt = 0, a0 = 0;
    // Protection writes and the value each should leave behind
    logic [7:0] pw [6] = '{8'hBE, 8'hFF, 8'h7C, 8'h7D, 8'hBB, 8'h3B};
    logic [7:0] pe [6] = '{8'hBE, 8'hBE, 8'h7C, 8'h7C, 8'h7C, 8'h3B};
    logic [15:0] va [4] = '{16'h17C0, 16'h17BF, 16'hE800, 16'hE7FF};
    logic [3:0] okb = 4'b1010;
    logic [7:0] cl [4] = '{8'h05, 8'h20, 8'h25, 8'h40};

    // 125 MHz bus clock
    initial begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end

    // Single slave, so its ready closes the loop onto hready
    nvpsc_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
        .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .stored_protection_image(img), .stored_security_image(simg),
        .stop_req_pin(stop_req_pin), .nvm_done(nvm_done), .nvm_blank_ok(nvm_blank_ok),
        .nvm_req(req), .nvm_go(nvm_go), .nvm_abort(nvm_abort),
        .nvm_clock_divider(div), .security_state_field(secst));

    // Count array starts and aborts so dropped pulses show up
    always @(posedge hclk) begin
        if (nvm_go === 1'b1)
            go_cnt <= go_cnt + 1;
        if (nvm_abort === 1'b1)
            ab_cnt <= ab_cnt + 1;
    end

    // ********************************
    // Checking and bus tasks
    // ********************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        $display("checks=%0d failures=%0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Bounded wait so a stuck ready ends as a mismatch, not a hang
    task automatic wait_rdy();
        int k;
        k = 0;
        do begin
            @(posedge hclk);
            k++;
        end while (hreadyout !== 1'b1 && k < 64);
        if (hreadyout !== 1'b1 || hresp !== 1'b0)
            failures++;
    endtask

    task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d);
        haddr <= {24'h00_0000, a};
        hwrite <= w;
        htrans <= 2'b10;
        wait_rdy();
        htrans <= 2'b00;
        hwdata <= {16'h0000, d};
        wait_rdy();
        rd = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        xfer(1'b1, a, d);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        xfer(1'b0, a, 16'h0000);
        chk(rd & {24'h00_0000, m}, {24'h00_0000, e});
    endtask

    // Full command sequence; three edges cover the launch-to-start latency
    task automatic launch(input logic [7:0] op, input logic [15:0] adr);
        wr(nvpsc_pkg::OFS_ADDR, adr);
        wr(nvpsc_pkg::OFS_DATA, 16'h005A);
        wr(nvpsc_pkg::OFS_CMD, {8'h00, op});
        g0 = go_cnt;
        a0 = ab_cnt;
        wr(nvpsc_pkg::OFS_STAT, 16'h0080);
        repeat (3) @(posedge hclk);
    endtask

    task automatic done_pulse(input logic ok);
        nvm_done <= 1'b1;
        nvm_blank_ok <= ok;
        @(posedge hclk);
        nvm_done <= 1'b0;
        @(posedge hclk);
    endtask

    // ********************************
    // Main sequence
    // ********************************
    initial begin
        hresetn = 1'b0;
        hsel = 1'b1;
        haddr = 32'h0000_0000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0000_0000;
        stop_req_pin = 1'b0;
        nvm_done = 1'b0;
        nvm_blank_ok = 1'b0;
        img = 8'hFE;
        simg = 2'b00;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        rdc(nvpsc_pkg::OFS_PROT, 8'hFF, 8'hFE);
        rdc(nvpsc_pkg::OFS_STAT, 8'hFF, 8'hC0);
        chk(secst, 2'b00);
        for (int i = 0; i < 6; i++) begin
            wr(nvpsc_pkg::OFS_PROT, {8'h00, pw[i]});
            rdc(nvpsc_pkg::OFS_PROT, 8'hFF, pe[i]);
        end
        // Program before the divider is set must be refused
        launch(nvpsc_pkg::CMD_BYTE_PROG, 16'h1000);
        chk(go_cnt - g0, 32'h0000_0000);
        rdc(nvpsc_pkg::OFS_STAT, 8'h30, 8'h10);
        wr(nvpsc_pkg::OFS_STAT, 16'h0000);
        rdc(nvpsc_pkg::OFS_STAT, 8'hFF, 8'hD0);
        wr(nvpsc_pkg::OFS_STAT, 16'h0010);
        rdc(nvpsc_pkg::OFS_STAT, 8'hFF, 8'hC0);
        wr(nvpsc_pkg::OFS_CDIV, 16'h000A);
        wr(nvpsc_pkg::OFS_CDIV, 16'h0015);
        launch(8'h33, 16'h1000);
        rdc(nvpsc_pkg::OFS_STAT, 8'h30, 8'h10);
        chk(div, 8'h0A);
        wr(nvpsc_pkg::OFS_STAT, 16'h0030);
        // Edges of the guarded areas, one inside and one just below
        for (int i = 0; i < 4; i++) begin
            launch(nvpsc_pkg::CMD_BYTE_PROG, va[i]);
            chk(go_cnt - g0, {31'h0000_0000, okb[i]});
            if (okb[i])
                done_pulse(1'b0);
            rdc(nvpsc_pkg::OFS_STAT, 8'hFF, okb[i] ? 8'hC0 : 8'hE0);
            wr(nvpsc_pkg::OFS_STAT, 16'h0020);
        end
        for (int i = 0; i < 4; i++) begin
            launch(cl[i], 16'h2000);
            chk(go_cnt - g0, 32'h0000_0001);
            chk(req.op, cl[i]);
            chk(req.data, 8'h5A);
            rdc(nvpsc_pkg::OFS_STAT, 8'hC0, 8'h80);
            done_pulse(i == 0);
            rdc(nvpsc_pkg::OFS_STAT, 8'hC4, i == 0 ? 8'hC4 : 8'hC0);
        end
        chk(secst, nvpsc_pkg::SECURITY_UNLOCKED);
        launch(nvpsc_pkg::CMD_MASS_ERASE, 16'h2000);
        rdc(nvpsc_pkg::OFS_STAT, 8'hF0, 8'hE0);
        wr(nvpsc_pkg::OFS_STAT, 16'h0020);
        launch(nvpsc_pkg::CMD_ERASE_ABORT, 16'h2000);
        rdc(nvpsc_pkg::OFS_STAT, 8'hF0, 8'hC0);
        chk(ab_cnt - a0, 32'h0000_0000);
        // Second burst waits in the buffer; a third launch is ignored
        launch(nvpsc_pkg::CMD_BURST_PROG, 16'h2000);
        launch(nvpsc_pkg::CMD_BURST_PROG, 16'h2001);
        chk(go_cnt - g0, 32'h0000_0000);
        rdc(nvpsc_pkg::OFS_STAT, 8'hC0, 8'h00);
        wr(nvpsc_pkg::OFS_STAT, 16'h0080);
        done_pulse(1'b0);
        chk(req.addr, 16'h2001);
        done_pulse(1'b0);
        rdc(nvpsc_pkg::OFS_STAT, 8'hF0, 8'hC0);
        // Abort reaches the array only while a sector erase runs
        launch(nvpsc_pkg::CMD_SECT_ERASE, 16'h2000);
        launch(nvpsc_pkg::CMD_ERASE_ABORT, 16'h2000);
        chk(ab_cnt - a0, 32'h0000_0001);
        done_pulse(1'b0);
        // Stop entry while an erase runs
        launch(nvpsc_pkg::CMD_SECT_ERASE, 16'h2000);
        stop_req_pin <= 1'b1;
        repeat (4) @(posedge hclk);
        stop_req_pin <= 1'b0;
        rdc(nvpsc_pkg::OFS_STAT, 8'h30, 8'h10);
        chk(ab_cnt - a0, 32'h0000_0001);
        // Second reset reloads an open image, so a mass erase may now run
        hresetn <= 1'b0;
        img <= 8'hFF;
        simg <= 2'b01;
        repeat (4) @(posedge hclk);
        chk(secst, nvpsc_pkg::SECURITY_RST);
        chk(div, 8'h00);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        rdc(nvpsc_pkg::OFS_PROT, 8'hFF, 8'hFF);
        rdc(nvpsc_pkg::OFS_STAT, 8'hFF, 8'hC0);
        chk(secst, 2'b01);
        wr(nvpsc_pkg::OFS_CDIV, 16'h000A);
        launch(nvpsc_pkg::CMD_MASS_ERASE, 16'h0000);
        chk(go_cnt - g0, 32'h0000_0001);
        done_pulse(1'b0);
        rdc(nvpsc_pkg::OFS_STAT, 8'hF0, 8'hC0);
        summarize();
    end

    // Watchdog well beyond the few hundred cycles the sequence needs
    initial begin
        #200_000;
        failures++;
        summarize();
    end
endmodule // nvpsc_top_bench
